/* common/irq_src_pkg.sv */
package irq_src_pkg;
   localparam logic [15:0] ADDR_GROUP0_PENDING = 16'h7f00;
   localparam logic [15:0] ADDR_GROUP0_MASK = 16'h7f01;
   localparam logic [15:0] ADDR_GROUP1_PENDING = 16'h7f02;
   localparam logic [15:0] ADDR_GROUP1_MASK = 16'h7f03;
   localparam logic [15:0] ADDR_RX_CTRL = 16'h7f04;
   localparam logic [7:0] RESET_PENDING = 8'h00;
   localparam logic [7:0] RESET_MASK0 = 8'hff;
   localparam logic [7:0] RESET_MASK1 = 8'hff;
   localparam logic [7:0] RESET_RX_CTRL = 8'h00;
   localparam int BIT_DMA = 0;
   localparam int BIT_TX_PACKET_DONE = 1;
   localparam int BIT_TX_EMPTY = 2;
   localparam int BIT_RX_PACKET_QUEUED = 3;
   localparam int BIT_EXT_LO = 4;
   localparam int BIT_WAKE = 0;
   localparam int BIT_OVERRUN = 1;
   localparam int BIT_SW_DONE_A = 2;
   localparam int BIT_SOF = 3;
   localparam int BIT_EOT = 4;
   localparam logic [7:0] GROUP1_IMPL = 8'h1f;
   localparam logic [10:0] NONISO_MAX_BYTES = 11'h040;
   localparam int N_TX_EP = 16;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic rx_queued;
      logic [N_TX_EP-1:0] tx_queue_drained;
      logic [N_TX_EP-1:0] tx_ep_enabled;
      logic tx_done;
      logic iso_in_missed;
      logic dma_tc_or_req;
      logic engine_idle;
      logic frame_count_wr;
      logic sw_sw_done_a_done;
      logic hw_sw_done_a_done;
      logic buffer_unavailable;
      logic wake_active;
   } events_t;

   typedef struct packed {
      logic end_valid;
      logic [10:0] length;
      logic iso;
      logic [10:0] iso_limit;
      logic ep_stalled;
   } rx_packet_queued_t;
endpackage : irq_src_pkg

/* verilog/mcu_interrupt_source_mask.sv */
// Local design decision: strobed register access.
module mcu_interrupt_source_mask
   import irq_src_pkg::*;
(
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire reg_req_t req_i,
   output logic [7:0] rdata_o,
   input wire logic [3:0] ext_int_in_i,
   input wire events_t ev_i,
   input wire rx_packet_queued_t rx_i,
   output logic rx_ack_o,
   output logic rx_discard_o,
   output logic rx_stall_o,
   output logic iso_move_done_o,
   output logic irq_group0_o,
   output logic irq_group1_o
);

   function automatic logic [7:0] w1c_next(input logic [7:0] cur,
                                           input logic [7:0] set,
                                           input logic clr_en,
                                           input logic [7:0] wd);
      // Set beats clear so an event in the clearing cycle is kept
      w1c_next = (cur & ~(clr_en ? wd : 8'h00)) | set;
   endfunction : w1c_next

   logic [3:0] ext_meta;
   logic [3:0] ext_sync;
   logic [3:0] ext_prev;
   logic dma_prev;
   logic [7:0] event_group0_pending;
   logic [7:0] event_group0_mask;
   logic [7:0] event_group1_pending;
   logic [7:0] event_group1_mask;
   logic [7:0] rx_ctrl;
   logic [7:0] next_pend0;
   logic [7:0] next_pend1;

   wire sel_p0 = req_i.addr == ADDR_GROUP0_PENDING;
   wire sel_m0 = req_i.addr == ADDR_GROUP0_MASK;
   wire sel_p1 = req_i.addr == ADDR_GROUP1_PENDING;
   wire sel_m1 = req_i.addr == ADDR_GROUP1_MASK;
   wire sel_rc = req_i.addr == ADDR_RX_CTRL;

   // External lines are asynchronous pins; flag their rising edge
   wire [3:0] ext_rise = ext_sync & ~ext_prev;
   wire dma_rise = ev_i.dma_tc_or_req & ~dma_prev;
   wire tx_empty_ev = |(ev_i.tx_queue_drained & ev_i.tx_ep_enabled);
   wire tx_packet_done_ev = ev_i.tx_done | ev_i.iso_in_missed;

   wire too_long = rx_i.iso ? (rx_i.length > rx_i.iso_limit)
                            : (rx_i.length > NONISO_MAX_BYTES);
   wire rx_bad = rx_i.end_valid & (too_long | rx_i.ep_stalled);
   wire overrun_ev = ev_i.buffer_unavailable | rx_bad;
   wire rx_good = rx_i.end_valid & ~rx_bad & ~ev_i.buffer_unavailable;

   wire [7:0] set0 = {ext_rise, ev_i.rx_queued, tx_empty_ev,
                      tx_packet_done_ev, dma_rise};
   wire [7:0] set1 = {3'b000, ev_i.engine_idle, ev_i.frame_count_wr,
                      ev_i.sw_sw_done_a_done, overrun_ev,
                      ev_i.wake_active};

   always_comb begin
      next_pend0 = w1c_next(event_group0_pending, set0,
                            req_i.wr & sel_p0, req_i.wdata);
      next_pend1 = w1c_next(event_group1_pending, set1,
                            req_i.wr & sel_p1, req_i.wdata);
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ext_meta <= 4'h0;
         ext_sync <= 4'h0;
         ext_prev <= 4'h0;
         dma_prev <= 1'b0;
      end else begin
         ext_meta <= ext_int_in_i;
         ext_sync <= ext_meta;
         ext_prev <= ext_sync;
         dma_prev <= ev_i.dma_tc_or_req;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         event_group0_pending <= RESET_PENDING;
         event_group1_pending <= RESET_PENDING;
      end else begin
         event_group0_pending <= next_pend0;
         event_group1_pending <= next_pend1 & GROUP1_IMPL;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         event_group0_mask <= RESET_MASK0;
         event_group1_mask <= RESET_MASK1;
         rx_ctrl <= RESET_RX_CTRL;
      end else begin
         if (req_i.wr && sel_m0)
            event_group0_mask <= req_i.wdata;
         if (req_i.wr && sel_m1)
            event_group1_mask <= req_i.wdata | ~GROUP1_IMPL;
         if (req_i.wr && sel_rc)
            rx_ctrl <= req_i.wdata & 8'h01;
      end
   end

   // Read mux; unmapped addresses read zero
   wire [7:0] rd_mux = sel_p0 ? event_group0_pending :
                       sel_m0 ? event_group0_mask :
                       sel_p1 ? event_group1_pending :
                       sel_m1 ? event_group1_mask :
                       sel_rc ? rx_ctrl : 8'h00;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i)
         rdata_o <= 8'h00;
      else
         rdata_o <= req_i.rd ? rd_mux : 8'h00;
   end

   // Receive verdicts are registered one cycle after the packet ends
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rx_ack_o <= 1'b0;
         rx_discard_o <= 1'b0;
         rx_stall_o <= 1'b0;
         iso_move_done_o <= 1'b0;
      end else begin
         rx_ack_o <= rx_good;
         rx_discard_o <= rx_bad | (rx_i.end_valid &
                         ev_i.buffer_unavailable);
         // Oversize stall can be disabled by software for bring-up
         rx_stall_o <= rx_i.end_valid & too_long & ~rx_i.iso
                       & ~rx_ctrl[0];
         iso_move_done_o <= ev_i.iso_in_missed;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         irq_group0_o <= 1'b0;
         irq_group1_o <= 1'b0;
      end else begin
         irq_group0_o <= |(next_pend0 & ~event_group0_mask);
         irq_group1_o <= |(next_pend1 & GROUP1_IMPL
                          & ~event_group1_mask);
      end
   end

endmodule : mcu_interrupt_source_mask

/* sim/irq_src_props.sv */
module irq_src_props
   import irq_src_pkg::*;
(
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire reg_req_t req_i,
   input wire events_t ev_i,
   input wire rx_packet_queued_t rx_i,
   input wire logic rx_ack_o,
   input wire logic rx_discard_o,
   input wire logic rx_stall_o,
   input wire logic iso_move_done_o,
   input wire logic irq_group0_o,
   input wire logic irq_group1_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   logic long_pkt;
   assign long_pkt = rx_i.end_valid && !rx_i.iso
      && rx_i.length > NONISO_MAX_BYTES;
   a_long_drop: assert property (long_pkt |=> rx_discard_o)
      else $error("long packet kept");
   a_stall_cause: assert property (rx_stall_o |-> $past(long_pkt))
      else $error("stall without long packet");
   a_stalled_drop: assert property
      (rx_i.end_valid && rx_i.ep_stalled |=> rx_discard_o)
      else $error("packet to stalled endpoint kept");
   a_drop_no_ack: assert property (!(rx_ack_o && rx_discard_o))
      else $error("dropped packet acknowledged");
   a_iso_move: assert property (ev_i.iso_in_missed |=> iso_move_done_o)
      else $error("missed token not moved");
   a_move_cause: assert property
      (iso_move_done_o |-> $past(ev_i.iso_in_missed))
      else $error("move without missed token");
   // Only a write can clear a pending bit or raise a mask
   a_ext_int_in0_hold: assert property
      (irq_group0_o && !req_i.wr |=> irq_group0_o)
      else $error("group0 request dropped");
   a_ext_int_in1_hold: assert property
      (irq_group1_o && !req_i.wr |=> irq_group1_o)
      else $error("group1 request dropped");
endmodule : irq_src_props
bind mcu_interrupt_source_mask irq_src_props u_props (.clk_i, .arst_n_i,
   .req_i, .ev_i, .rx_i, .rx_ack_o, .rx_discard_o, .rx_stall_o,
   .iso_move_done_o, .irq_group0_o, .irq_group1_o);

/* sim/fw_model.sv */
module fw_model
   import irq_src_pkg::*;
(
   input wire logic clk_i,
   input wire logic [7:0] rdata_i,
   output reg_req_t req_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial req_o = '0;
   // One idle cycle between accesses keeps strobes single-driven
   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      @(posedge clk_i) req_o <= '{a, v, 1'b1, 1'b0};
      @(posedge clk_i) req_o <= '0;
   endtask : wr
   task automatic rd(input logic [15:0] a, output logic [7:0] v);
      @(posedge clk_i) req_o <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk_i) req_o <= '0;
      #1 v = rdata_i;
   endtask : rd
endmodule : fw_model

/* sim/testbench.sv */
module testbench
   import irq_src_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   reg_req_t req;
   logic [7:0] rdata, d;
   logic [3:0] ext = 4'h0;
   events_t ev = '0;
   rx_packet_queued_t rx = '0;
   logic ack, drop, stall, ext_int_in0, ext_int_in1, mv;
   logic mopen = 1'b0;
   int num_errors = 0;
   int tests_run = 0;
   always #50 clk_i = ~clk_i;
   fw_model fw (.clk_i, .rdata_i(rdata), .req_o(req));
   mcu_interrupt_source_mask dut (.clk_i, .arst_n_i, .req_i(req),
      .rdata_o(rdata), .ext_int_in_i(ext), .ev_i(ev), .rx_i(rx),
      .rx_ack_o(ack), .rx_discard_o(drop), .rx_stall_o(stall),
      .iso_move_done_o(mv), .irq_group0_o(ext_int_in0), .irq_group1_o(ext_int_in1));
   task automatic check(input logic [7:0] s, x);
      tests_run++;
      if (s !== x) begin
         num_errors++;
         $display("Error at %0t: got %h want %h", $time, s, x);
      end
   endtask : check
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] x);
      fw.rd(a, d);
      check(d, x);
   endtask : rd_chk
   task automatic print_verdict;
      $display("%0d checks, %0d errors", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : print_verdict
   // Pulse event bits a and b, then clear by writing ones
   task automatic ev_chk(input int a, b, input logic [15:0] ad,
      input logic [7:0] x);
      events_t e;
      logic [1:0] w;
      e = '0;
      e[a] = 1'b1;
      e[b] = 1'b1;
      w = (ad == ADDR_GROUP1_PENDING) ? 2'b10 : 2'b01;
      @(posedge clk_i) ev <= e;
      @(posedge clk_i) ev <= '0;
      #1 check(8'({ext_int_in1, ext_int_in0}), 8'((mopen && |x) ? w : 2'b00));
      check(8'(mv), 8'(a == 7));
      rd_chk(ad, x);
      fw.wr(ad, 8'h00);
      rd_chk(ad, x);
      fw.wr(ad, x);
      rd_chk(ad, 8'h00);
      check(8'({ext_int_in1, ext_int_in0}), 8'h00);
      $display("test done: event %0d", a);
   endtask : ev_chk
   task automatic rxp(input logic [10:0] n, input logic iso, st,
      input logic [2:0] x);
      @(posedge clk_i) rx <= '{1'b1, n, iso, 11'h064, st};
      @(posedge clk_i) rx <= '0;
      #1 check(8'({ack, drop, stall}), 8'(x));
      rd_chk(ADDR_GROUP1_PENDING, x[1] ? 8'h02 : 8'h00);
      fw.wr(ADDR_GROUP1_PENDING, 8'h02);
      $display("test done: packet length %0d", n);
   endtask : rxp
   initial begin
      repeat (16) @(posedge clk_i);
      arst_n_i <= 1'b1;
      rd_chk(ADDR_GROUP0_MASK, RESET_MASK0);
      rd_chk(ADDR_GROUP1_MASK, RESET_MASK1);
      rd_chk(ADDR_GROUP0_PENDING, RESET_PENDING);
      rd_chk(16'h7f05, 8'h00);
      ev_chk(41, 41, ADDR_GROUP0_PENDING, 8'h08);
      fw.wr(ADDR_GROUP0_MASK, 8'h00);
      fw.wr(ADDR_GROUP1_MASK, 8'h00);
      rd_chk(ADDR_GROUP1_MASK, 8'he0);
      mopen = 1'b1;
      ev_chk(41, 41, ADDR_GROUP0_PENDING, 8'h08);
      ev_chk(30, 14, ADDR_GROUP0_PENDING, 8'h04);
      ev_chk(30, 30, ADDR_GROUP0_PENDING, 8'h00);
      ev_chk(8, 8, ADDR_GROUP0_PENDING, 8'h02);
      ev_chk(7, 7, ADDR_GROUP0_PENDING, 8'h02);
      ev_chk(6, 6, ADDR_GROUP0_PENDING, 8'h01);
      ev_chk(6, 6, ADDR_GROUP0_PENDING, 8'h01);
      ev_chk(5, 5, ADDR_GROUP1_PENDING, 8'h10);
      ev_chk(4, 4, ADDR_GROUP1_PENDING, 8'h08);
      ev_chk(3, 3, ADDR_GROUP1_PENDING, 8'h04);
      ev_chk(2, 2, ADDR_GROUP1_PENDING, 8'h00);
      ev_chk(1, 1, ADDR_GROUP1_PENDING, 8'h02);
      ev_chk(0, 0, ADDR_GROUP1_PENDING, 8'h01);
      @(posedge clk_i) ext <= 4'h1;
      repeat (4) @(posedge clk_i);
      ext <= 4'h0; // Nonblocking so the edge sees a settled pin
      rd_chk(ADDR_GROUP0_PENDING, 8'h10);
      fw.wr(ADDR_GROUP0_PENDING, 8'h10);
      rxp(11'h040, 1'b0, 1'b0, 3'b100);
      rxp(11'h041, 1'b0, 1'b0, 3'b011);
      rxp(11'h065, 1'b1, 1'b0, 3'b010);
      rxp(11'h008, 1'b0, 1'b1, 3'b010);
      fw.wr(ADDR_RX_CTRL, 8'h01);
      rd_chk(ADDR_RX_CTRL, 8'h01);
      rxp(11'h041, 1'b0, 1'b0, 3'b010);
      fw.wr(ADDR_RX_CTRL, 8'h00);
      print_verdict();
   end
   // Watchdog: a hang counts as a mismatch
   initial begin
      #3000000;
      num_errors++;
      print_verdict();
   end
endmodule : testbench
